// [logic/ctv_consts.svh]
/*
 * Timing counts, field positions and build options of the pixel-side video port.
 * Assumes a 25 MHz core clock that is also the pixel clock.
 */
`ifndef CTV_CONSTS_SVH
`define CTV_CONSTS_SVH

// ==========================================================
// Clock and build options
`define CTV_CLK_PERIOD_NS 40
`define CTV_PHY_RATE_MHZ 1500
`define CTV_PHY_RATE_MIN_MHZ 80
`define CTV_PHY_RATE_MAX_MHZ 1500
`define CTV_ESCAPE_CLOCK_MHZ 20
`define CTV_CONT_CLK 1'b0
// Three bits per physical lane, lane 0 in the low bits
`define CTV_LANE_MAP_DEF 15'h4688
`define CTV_ROLE_CLK 3'h0

// ==========================================================
// Lane timers
`define CTV_SLEEP_MIN_NS 5000
`define CTV_SLEEP_MIN_CYC ((`CTV_SLEEP_MIN_NS + `CTV_CLK_PERIOD_NS - 1) / `CTV_CLK_PERIOD_NS)
`define CTV_CLK_PRE_NS 100
`define CTV_CLK_PRE_EDGES ((`CTV_CLK_PRE_NS * `CTV_ESCAPE_CLOCK_MHZ + 999) / 1000)
`define CTV_CLK_PREP_CYC 2
`define CTV_CLK_ZERO_CYC 4
`define CTV_CLK_POST_CYC 2
`define CTV_CLK_TRAIL_CYC 2
`define CTV_HS_PREP_CYC 2
`define CTV_HS_ZERO_CYC 4
`define CTV_HS_TRAIL_CYC 3

// ==========================================================
// Line header word layout
`define CTV_HDR_CNT_LSB 0
`define CTV_HDR_TYPE_LSB 16
`define CTV_HDR_VC_LSB 22
`define CTV_HDR_MODE_BIT 24

`endif

// [logic/ctv_pkg.sv]
/*
 * Types of the video port.
 * Assumes ctv_consts.svh for all numbers.
 */
package ctv_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CLK_PREP, ST_CLK_ZERO, ST_CLK_PRE, ST_HS_PREP,
    ST_HS_ZERO, ST_HS_DATA, ST_HS_TRAIL, ST_CLK_POST, ST_CLK_TRAIL
  } ctv_state_t;
endpackage

// [logic/ctv_pair_buf.sv]
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes one clock, active-high asynchronous reset, clock enable.
 */
module ctv_pair_buf (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [63:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [63:0] out_data_o
);
  logic [63:0] mem_ff [2];
  logic [63:0] nxt_mem [2];
  logic wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = ce_i & in_valid_i & in_ready_o; // [R20]
  assign pop = ce_i & out_valid_o & out_ready_i;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data_i;
      nxt_wr = ~wr_ff;
    end
    if (pop) begin
      nxt_rd = ~rd_ff;
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_ff[0] <= 64'h0;
      mem_ff[1] <= 64'h0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  AST_IGNORE_INVALID: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R20]
    !in_valid_i |=> cnt_ff <= $past(cnt_ff)) else $error("word stored without valid");
  AST_FULL_STALLS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R2]
    cnt_ff == 2'h2 |-> !in_ready_o ##1 cnt_ff != 2'h0) else $error("full buffer not stalling");
endmodule // ctv_pair_buf

// [logic/ctv_video_port.sv]
/*
 * Pixel-side video port of a camera-serial transmitter: frame and line capture,
 * word buffering, lane serialising with lane timers, lane sleep handling, lane mapping.
 * Assumes core_clk_i is the pixel clock; video inputs come from logic on that clock,
 * while escape clock and both lane resets arrive from outside and are synchronised.
 */
// Overview of operation
// R1: Line length changes only with vertical sync low; latched at its rise.
// R2: 64-bit pixel words on pixel clock, one per cycle possible.
// R3: Data type changes only with horizontal sync low; latched at its rise.
// R4: Frame format select, general or accurate, is taken only during reset.
// R5: Virtual channel changes only with vertical sync low; latched at its rise.
// R6: Clock-lane sleep entry is a pulse of at least 5 us, never with exit.
// R7: Clock-lane sleep exit is a pulse of at least 5 us, never with entry.
// R8: Each data-lane sleep entry bit pulses at least 5 us, not with exit.
// R9: Each data-lane sleep exit bit pulses at least 5 us, not with entry.
// R10: Five differential pad pairs, one clock lane and four data lanes.
// R11: Each physical lane is mapped at build time to clock or a data lane.
// R12: Build option: clock lane runs continuously or gated between bursts.
// R13: PHY rate is fixed at build time between 80 and 1500 MHz.
// R14: PLL reference clock is one of the listed frequencies.
// R15: Escape clock lies between 11 and 20 MHz, declared at build time.
// R16: Clock and data lane prepare, zero, trail, post timers are build settings.
// R17: Clock-lane pre interval is counted from the escape clock.
// R18: Lane count 00 one lane, 01 two lanes, 11 four; taken during reset.
// R19: Controller reset alone for line length change, else both resets.
// R20: A pixel word is captured only when valid is high.
`include "ctv_consts.svh"

module ctv_video_port #(
  parameter logic [14:0] LANE_MAP = `CTV_LANE_MAP_DEF,
  parameter logic CONT_CLK = `CTV_CONT_CLK
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic controller_reset_n_i,
  input wire logic phy_reset_n_i,
  input wire logic escape_clock_i,
  input wire logic frame_vsync_i,
  input wire logic line_hsync_i,
  input wire logic pixel_valid_i,
  input wire logic [63:0] pixel_data_i,
  input wire logic [15:0] line_pixel_count_i,
  input wire logic [5:0] data_type_i,
  input wire logic frame_mode_i,
  input wire logic [1:0] virtual_channel_id_i,
  input wire logic [1:0] lane_count_i,
  input wire logic clock_lane_sleep_enter_i,
  input wire logic clock_lane_sleep_exit_i,
  input wire logic [3:0] data_lane_sleep_enter_i,
  input wire logic [3:0] data_lane_sleep_exit_i,
  output logic pixel_ready_o,
  output logic [4:0] lane_pad_pos_o,
  output logic [4:0] lane_pad_neg_o,
  output logic clock_lane_asleep_o,
  output logic [3:0] data_lane_asleep_o,
  output logic hs_active_o
);
  localparam int SLEEP_MIN = `CTV_SLEEP_MIN_CYC;
  localparam logic [7:0] CLK_PRE = 8'(`CTV_CLK_PRE_EDGES);

  // ==========================================================
  // Synchronisers for pins from outside the clock domain
  logic [2:0] sync1_ff, sync2_ff;
  logic esc_old_ff;
  logic ctrl_rst, phy_rst, esc_edge;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      esc_old_ff <= 1'b0;
    end else if (ce_i) begin
      sync1_ff <= {escape_clock_i, phy_reset_n_i, controller_reset_n_i};
      sync2_ff <= sync1_ff;
      esc_old_ff <= sync2_ff[2];
    end
  end
  assign ctrl_rst = ~sync2_ff[0];
  assign phy_rst = ~sync2_ff[1];
  assign esc_edge = sync2_ff[2] & ~esc_old_ff; // [R17]

  // ==========================================================
  // Frame and line attributes
  logic [15:0] hres_ff, nxt_hres;
  logic [5:0] dtype_ff, nxt_dtype;
  logic [1:0] vc_ff, nxt_vc, lanes_ff, nxt_lanes;
  logic fmode_ff, nxt_fmode, vs_old_ff, hs_old_ff, hdr_pend_ff, nxt_hdr_pend, hdr_take;
  always_comb begin
    nxt_hres = hres_ff;
    nxt_dtype = dtype_ff;
    nxt_vc = vc_ff;
    nxt_lanes = lanes_ff;
    nxt_fmode = fmode_ff;
    nxt_hdr_pend = hdr_pend_ff & ~hdr_take;
    if (ctrl_rst) begin
      nxt_lanes = lane_count_i; // [R18]
      nxt_fmode = frame_mode_i; // [R4]
      nxt_hres = 16'h0; // [R19]
      nxt_hdr_pend = 1'b0;
    end else begin
      if (frame_vsync_i && !vs_old_ff) begin
        nxt_hres = line_pixel_count_i; // [R1]
        nxt_vc = virtual_channel_id_i; // [R5]
      end
      if (line_hsync_i && !hs_old_ff) begin
        nxt_dtype = data_type_i; // [R3]
        // A new line start while vertical sync is high wins over the clear of the previous one
        nxt_hdr_pend = frame_vsync_i | nxt_hdr_pend;
      end
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hres_ff <= 16'h0;
      dtype_ff <= 6'h0;
      vc_ff <= 2'h0;
      lanes_ff <= 2'h0;
      fmode_ff <= 1'b0;
      vs_old_ff <= 1'b0;
      hs_old_ff <= 1'b0;
      hdr_pend_ff <= 1'b0;
    end else if (ce_i) begin
      hres_ff <= nxt_hres;
      dtype_ff <= nxt_dtype;
      vc_ff <= nxt_vc;
      lanes_ff <= nxt_lanes;
      fmode_ff <= nxt_fmode;
      vs_old_ff <= frame_vsync_i;
      hs_old_ff <= line_hsync_i;
      hdr_pend_ff <= nxt_hdr_pend;
    end
  end

  // ==========================================================
  // Word buffer between pixel bus and serialiser
  logic buf_valid, buf_pop;
  logic [63:0] buf_data;
  ctv_pair_buf u_buf (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .in_valid_i(pixel_valid_i),
    .in_ready_o(pixel_ready_o),
    .in_data_i(pixel_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_data)
  );

  // ==========================================================
  // Lane sleep requests: index 4 is the clock lane
  logic [4:0] sl_enter, sl_exit, asleep;
  assign sl_enter = {clock_lane_sleep_enter_i, data_lane_sleep_enter_i};
  assign sl_exit = {clock_lane_sleep_exit_i, data_lane_sleep_exit_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sleep
      logic [7:0] cnt_ff, nxt_cnt;
      logic sl_ff, nxt_sl;
      always_comb begin
        nxt_cnt = 8'h0;
        nxt_sl = sl_ff;
        // Overlapping requests are ignored; only a long single request acts
        if (sl_enter[gi] ^ sl_exit[gi]) begin // [R6] [R7] [R8] [R9]
          nxt_cnt = (cnt_ff == 8'(SLEEP_MIN)) ? cnt_ff : cnt_ff + 8'h1;
          if (cnt_ff == 8'(SLEEP_MIN - 1)) begin
            nxt_sl = sl_enter[gi];
          end
        end
        if (phy_rst) begin
          nxt_sl = 1'b0;
        end
      end
      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cnt_ff <= 8'h0;
          sl_ff <= 1'b0;
        end else if (ce_i) begin
          cnt_ff <= nxt_cnt;
          sl_ff <= nxt_sl;
        end
      end
      assign asleep[gi] = sl_ff;
    end
  endgenerate
  assign clock_lane_asleep_o = asleep[4];
  assign data_lane_asleep_o = asleep[3:0];

  // ==========================================================
  // Burst sequencer and serialiser
  ctv_pkg::ctv_state_t st_ff, nxt_st;
  logic [7:0] tmr_ff, nxt_tmr;
  logic [5:0] beat_ff, nxt_beat;
  logic [63:0] sh_ff, nxt_sh;
  logic tgl_ff, nxt_tgl;
  logic [3:0] lane_en;
  logic [5:0] beats_last;
  logic work, clk_hs;

  always_comb begin
    case (lanes_ff) // [R18]
      2'h1: begin lane_en = 4'h3; beats_last = 6'd31; end
      2'h3: begin lane_en = 4'hf; beats_last = 6'd15; end
      default: begin lane_en = 4'h1; beats_last = 6'd63; end
    endcase
  end
  assign work = hdr_pend_ff | buf_valid;

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff + 8'h1;
    nxt_beat = beat_ff;
    nxt_sh = sh_ff;
    hdr_take = 1'b0;
    buf_pop = 1'b0;
    case (st_ff)
      ctv_pkg::ST_IDLE: begin
        nxt_tmr = 8'h0;
        if (work && !asleep[4] && ((asleep[3:0] & lane_en) == 4'h0)) begin
          nxt_st = (CONT_CLK) ? ctv_pkg::ST_CLK_PRE : ctv_pkg::ST_CLK_PREP; // [R12]
        end
      end
      ctv_pkg::ST_CLK_PREP: if (tmr_ff == 8'(`CTV_CLK_PREP_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_CLK_ZERO;
        nxt_tmr = 8'h0;
      end
      ctv_pkg::ST_CLK_ZERO: if (tmr_ff == 8'(`CTV_CLK_ZERO_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_CLK_PRE;
        nxt_tmr = 8'h0;
      end
      ctv_pkg::ST_CLK_PRE: begin
        nxt_tmr = tmr_ff + {7'h0, esc_edge}; // [R17]
        if (esc_edge && tmr_ff == CLK_PRE - 8'h1) begin
          nxt_st = ctv_pkg::ST_HS_PREP;
          nxt_tmr = 8'h0;
        end
      end
      ctv_pkg::ST_HS_PREP: if (tmr_ff == 8'(`CTV_HS_PREP_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_HS_ZERO;
        nxt_tmr = 8'h0;
      end
      ctv_pkg::ST_HS_ZERO: if (tmr_ff == 8'(`CTV_HS_ZERO_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_HS_DATA;
        nxt_beat = 6'h0;
      end
      ctv_pkg::ST_HS_DATA: begin
        nxt_tmr = 8'h0;
        nxt_beat = beat_ff - 6'h1;
        nxt_sh = sh_ff >> lane_en_count(lane_en);
      end
      ctv_pkg::ST_HS_TRAIL: if (tmr_ff == 8'(`CTV_HS_TRAIL_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_CLK_POST;
        nxt_tmr = 8'h0;
      end
      ctv_pkg::ST_CLK_POST: if (tmr_ff == 8'(`CTV_CLK_POST_CYC - 1)) begin // [R16]
        nxt_st = (CONT_CLK) ? ctv_pkg::ST_IDLE : ctv_pkg::ST_CLK_TRAIL; // [R12]
        nxt_tmr = 8'h0;
      end
      ctv_pkg::ST_CLK_TRAIL: if (tmr_ff == 8'(`CTV_CLK_TRAIL_CYC - 1)) begin // [R16]
        nxt_st = ctv_pkg::ST_IDLE;
      end
      default: nxt_st = ctv_pkg::ST_IDLE;
    endcase
    // Loading on the last zero cycle keeps stale bits off the first data cycle
    if ((st_ff == ctv_pkg::ST_HS_ZERO && nxt_st == ctv_pkg::ST_HS_DATA) ||
        (st_ff == ctv_pkg::ST_HS_DATA && beat_ff == 6'h0)) begin
      nxt_tmr = 8'h0;
      nxt_beat = beats_last;
      // The header of a new line goes ahead of its first pixel word
      if (hdr_pend_ff) begin
        hdr_take = 1'b1;
        nxt_sh = 64'h0;
        nxt_sh[`CTV_HDR_CNT_LSB +: 16] = hres_ff;
        nxt_sh[`CTV_HDR_TYPE_LSB +: 6] = dtype_ff;
        nxt_sh[`CTV_HDR_VC_LSB +: 2] = vc_ff;
        nxt_sh[`CTV_HDR_MODE_BIT] = fmode_ff;
      end else if (buf_valid) begin
        buf_pop = 1'b1; // [R2]
        nxt_sh = buf_data;
      end else begin
        nxt_st = ctv_pkg::ST_HS_TRAIL;
      end
    end
    if (phy_rst) begin
      nxt_st = ctv_pkg::ST_IDLE;
      buf_pop = 1'b0;
      hdr_take = 1'b0;
    end
  end

  function automatic logic [6:0] lane_en_count(input logic [3:0] en);
    lane_en_count = (en == 4'hf) ? 7'd4 : ((en == 4'h3) ? 7'd2 : 7'd1);
  endfunction

  assign clk_hs = (CONT_CLK && !asleep[4] && !phy_rst) || // [R12]
    (st_ff inside {ctv_pkg::ST_CLK_PRE, ctv_pkg::ST_HS_PREP, ctv_pkg::ST_HS_ZERO,
                   ctv_pkg::ST_HS_DATA, ctv_pkg::ST_HS_TRAIL, ctv_pkg::ST_CLK_POST});
  assign nxt_tgl = clk_hs ? ~tgl_ff : 1'b0;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= ctv_pkg::ST_IDLE;
      tmr_ff <= 8'h0;
      beat_ff <= 6'h0;
      sh_ff <= 64'h0;
      tgl_ff <= 1'b0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      beat_ff <= nxt_beat;
      sh_ff <= nxt_sh;
      tgl_ff <= nxt_tgl;
    end
  end
  assign hs_active_o = (st_ff == ctv_pkg::ST_HS_DATA);

  // ==========================================================
  // Logical lane levels, index 4 is the clock lane
  logic [4:0] lg_pos, lg_neg;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (asleep[k] || !lane_en[k]) begin
        lg_pos[k] = asleep[k] ? 1'b0 : 1'b1;
        lg_neg[k] = lg_pos[k];
      end else begin
        case (st_ff)
          ctv_pkg::ST_HS_PREP: begin lg_pos[k] = 1'b0; lg_neg[k] = 1'b0; end
          ctv_pkg::ST_HS_ZERO: begin lg_pos[k] = 1'b0; lg_neg[k] = 1'b1; end
          ctv_pkg::ST_HS_DATA, ctv_pkg::ST_HS_TRAIL: begin // [R10]
            lg_pos[k] = (st_ff == ctv_pkg::ST_HS_DATA) ? sh_ff[k] : ~sh_ff[0];
            lg_neg[k] = ~lg_pos[k];
          end
          default: begin lg_pos[k] = 1'b1; lg_neg[k] = 1'b1; end
        endcase
      end
    end
    if (clk_hs) begin
      lg_pos[4] = tgl_ff;
      lg_neg[4] = ~tgl_ff;
    end else if (asleep[4] || st_ff == ctv_pkg::ST_CLK_PREP) begin
      lg_pos[4] = 1'b0;
      lg_neg[4] = 1'b0;
    end else begin
      lg_pos[4] = (st_ff != ctv_pkg::ST_CLK_ZERO);
      lg_neg[4] = 1'b1;
    end
  end

  // ==========================================================
  // Pad mapping, registered so the pads never glitch
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pad
      logic [2:0] role;
      logic [2:0] idx;
      assign role = LANE_MAP[3 * gi +: 3];
      assign idx = (role == `CTV_ROLE_CLK) ? 3'h4 : role - 3'h1; // [R11]
      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          lane_pad_pos_o[gi] <= 1'b1;
          lane_pad_neg_o[gi] <= 1'b1;
        end else if (ce_i) begin
          lane_pad_pos_o[gi] <= lg_pos[idx]; // [R10]
          lane_pad_neg_o[gi] <= lg_neg[idx];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  sequence s_hs_prep;
    (st_ff == ctv_pkg::ST_HS_PREP)[*2] ##1 st_ff == ctv_pkg::ST_HS_ZERO;
  endsequence
  sequence s_hs_trail;
    (st_ff == ctv_pkg::ST_HS_TRAIL)[*3] ##1 st_ff == ctv_pkg::ST_CLK_POST;
  endsequence
  AST_WORD_TAKEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R20]
    ce_i && pixel_valid_i && pixel_ready_o |=> buf_valid) else $error("valid word lost");
  AST_HS_PREP_LEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !ce_i || phy_rst) // [R16]
    $rose(st_ff == ctv_pkg::ST_HS_PREP) |-> s_hs_prep) else $error("data prepare length wrong");
  AST_HS_TRAIL_LEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !ce_i || phy_rst) // [R16]
    $rose(st_ff == ctv_pkg::ST_HS_TRAIL) |-> s_hs_trail) else $error("data trail length wrong");
  AST_CLK_PRE_ESC: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R17]
    $rose(st_ff == ctv_pkg::ST_HS_PREP) |-> $past(tmr_ff) == CLK_PRE - 8'h1 && $past(esc_edge))
    else $error("clock pre not counted in escape edges");
  AST_SETUP_HELD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R4] [R18]
    !ctrl_rst && ce_i |=> $stable(lanes_ff) && $stable(fmode_ff)) else $error("setup changed out of reset");
  AST_DIFF_DATA: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // [R10]
    st_ff == ctv_pkg::ST_HS_DATA |->
      ((lg_pos[3:0] ^ lg_neg[3:0]) & lane_en) == (lane_en & ~asleep[3:0]))
    else $error("enabled data lane not differential");
  AST_CLK_RUNS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !ce_i) // [R12]
    clk_hs ##1 clk_hs |-> tgl_ff != $past(tgl_ff)) else $error("clock lane not toggling");
  AST_PHY_RATE: assert property (@(posedge core_clk_i) // [R13]
    `CTV_PHY_RATE_MHZ >= `CTV_PHY_RATE_MIN_MHZ && `CTV_PHY_RATE_MHZ <= `CTV_PHY_RATE_MAX_MHZ)
    else $error("phy rate out of range");
  AST_LINE_LATCH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !ce_i) // [R1]
    $rose(frame_vsync_i) && !ctrl_rst && vs_old_ff == 1'b0 |=> hres_ff == $past(line_pixel_count_i))
    else $error("line length not latched");
endmodule // ctv_video_port

// [verif/ctv_src_model.sv]
/*
 * Behavioural video source standing where fabric logic feeds the video port.
 * Assumes the bench fills the word queue and calls send_line; one clock domain.
 */
module ctv_src_model (
  input wire logic core_clk_i,
  input wire logic pixel_ready_i,
  output logic frame_vsync_o,
  output logic line_hsync_o,
  output logic pixel_valid_o,
  output logic [63:0] pixel_data_o,
  output logic [15:0] line_pixel_count_o,
  output logic [5:0] data_type_o,
  output logic [1:0] virtual_channel_id_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] words[$];
  logic idle = 1'b1;
  initial begin
    frame_vsync_o = 1'b0;
    line_hsync_o = 1'b0;
    pixel_valid_o = 1'b0;
    pixel_data_o = 64'h0;
    line_pixel_count_o = 16'h0;
    data_type_o = 6'h0;
    virtual_channel_id_o = 2'h0;
  end
  // Idle bus keeps changing so a stale word can never look valid
  always @(posedge core_clk_i) begin
    if (idle) pixel_data_o <= ~pixel_data_o;
  end
  // ==========================================================
  // One line of a one-line frame
  task automatic send_line(input logic [15:0] cnt, input logic [5:0] typ, input logic [1:0] vc);
    logic r;
    @(posedge core_clk_i);
    idle <= 1'b0;
    line_pixel_count_o <= cnt;
    virtual_channel_id_o <= vc;
    data_type_o <= typ;
    @(posedge core_clk_i);
    frame_vsync_o <= 1'b1;
    @(posedge core_clk_i);
    line_hsync_o <= 1'b1;
    for (int i = 0; i < words.size(); i++) begin
      @(posedge core_clk_i);
      pixel_valid_o <= 1'b1;
      pixel_data_o <= words[i];
      r = 1'b0;
      while (!r) begin
        @(negedge core_clk_i);
        r = pixel_ready_i;
        @(posedge core_clk_i);
      end
      // Bubble with junk data that must be ignored
      pixel_valid_o <= 1'b0;
      pixel_data_o <= ~words[i];
    end
    @(posedge core_clk_i);
    line_hsync_o <= 1'b0;
    frame_vsync_o <= 1'b0;
    idle <= 1'b1;
  endtask
endmodule // ctv_src_model

// [verif/test_csi2_tx_video_port.sv]
/*
 * Self-checking bench of the video port: reset, lane sleep, serial stream per lane count.
 * Assumes default lane map (clock on pad 0, data lane k on pad k+1) and gated clock.
 */
`include "ctv_consts.svh"
module test_csi2_tx_video_port;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
  int mismatches = 0;
  int cmp_count = 0;
  int nl = 1;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ctl_rst_n = 1'b0, phy_rst_n = 1'b0, esc = 1'b0;
  logic vs, hs, vld, ready, ck_asleep, hs_act, frame_mode = 1'b0;
  logic [63:0] dat;
  logic [15:0] cnt;
  logic [5:0] typ;
  logic [1:0] vc, lane_count = 2'b00;
  logic ck_enter = 1'b0, ck_exit = 1'b0;
  logic [3:0] dl_enter = 4'h0, dl_exit = 4'h0, dl_asleep;
  logic [4:0] pad_p, pad_n;
  logic hs_q = 1'b0, p0_q = 1'b1, stall_seen = 1'b0, clk_tog = 1'b0;
  logic q[$];
  initial begin
    forever #20 clk = ~clk;
  end
  // Escape clock free running, slowed so the core clock sees every edge
  // No PLL reference here: pads are paced by the core clock
  initial begin
    #7;
    forever #160 esc = ~esc;
  end
  ctv_video_port dut_u (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce),
    .controller_reset_n_i(ctl_rst_n), .phy_reset_n_i(phy_rst_n), .escape_clock_i(esc),
    .frame_vsync_i(vs), .line_hsync_i(hs), .pixel_valid_i(vld), .pixel_data_i(dat),
    .line_pixel_count_i(cnt), .data_type_i(typ), .frame_mode_i(frame_mode),
    .virtual_channel_id_i(vc), .lane_count_i(lane_count),
    .clock_lane_sleep_enter_i(ck_enter), .clock_lane_sleep_exit_i(ck_exit),
    .data_lane_sleep_enter_i(dl_enter), .data_lane_sleep_exit_i(dl_exit),
    .pixel_ready_o(ready), .lane_pad_pos_o(pad_p), .lane_pad_neg_o(pad_n),
    .clock_lane_asleep_o(ck_asleep), .data_lane_asleep_o(dl_asleep), .hs_active_o(hs_act));
  ctv_src_model src_u (.core_clk_i(clk), .pixel_ready_i(ready), .frame_vsync_o(vs),
    .line_hsync_o(hs), .pixel_valid_o(vld), .pixel_data_o(dat), .line_pixel_count_o(cnt),
    .data_type_o(typ), .virtual_channel_id_o(vc));
  // ==========================================================
  // Stream capture at the falling edge; pads lag the state by one cycle
  always @(negedge clk) begin
    hs_q <= hs_act;
    p0_q <= pad_p[0];
    if (!ready) stall_seen <= 1'b1;
    if (hs_q) begin
      for (int k = 0; k < nl; k++) q.push_back(pad_p[k + 1]);
      if (pad_p[0] != p0_q) clk_tog <= 1'b1;
      `CHK("lane_pad_neg", ~pad_p[1], pad_n[1])
    end
  end
  function automatic logic [63:0] hdr(input logic m, input logic [1:0] v, input logic [5:0] t,
                                      input logic [15:0] c);
    return {39'h0, m, v, t, c};
  endfunction
  task automatic test_done;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Full reset; lane count and frame mode change only here
  task automatic do_reset(input logic [1:0] lc, input logic fm);
    @(posedge clk);
    rst <= 1'b1;
    ctl_rst_n <= 1'b0;
    phy_rst_n <= 1'b0;
    lane_count <= lc;
    frame_mode <= fm;
    nl = (lc == 2'b11) ? 4 : ((lc == 2'b01) ? 2 : 1);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    ctl_rst_n <= 1'b1;
    phy_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("pads_after_reset", 10'h3ff, {pad_p, pad_n})
    `CHK("idle_outputs", 7'h40, {ready, hs_act, dl_asleep, ck_asleep})
  endtask
  // Bit 0 clock lane, bits 4:1 data lanes 3..0
  task automatic sleep_try(input int n, input logic [4:0] en, input logic [4:0] ex,
                           input logic [4:0] exp);
    @(posedge clk);
    {dl_enter, ck_enter} <= en;
    {dl_exit, ck_exit} <= ex;
    repeat (n) @(posedge clk);
    {dl_enter, ck_enter} <= 5'h00;
    {dl_exit, ck_exit} <= 5'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("lane_asleep", exp, {dl_asleep, ck_asleep})
  endtask
  task automatic run_line(input int nw);
    logic [63:0] exp[$];
    logic [63:0] got;
    logic [63:0] w64;
    logic [15:0] c;
    logic [5:0] t;
    logic [1:0] v;
    int w;
    c = 16'($urandom);
    t = 6'($urandom);
    v = 2'($urandom);
    exp.push_back(hdr(frame_mode, v, t, c));
    src_u.words.delete();
    q.delete();
    for (int i = 0; i < nw; i++) begin
      w64 = (i == 0) ? 64'h8000_0000_0000_0001 : {$urandom, $urandom};
      exp.push_back(w64);
      src_u.words.push_back(w64);
    end
    stall_seen = 1'b0;
    clk_tog = 1'b0;
    src_u.send_line(c, t, v);
    w = 0;
    while (q.size() < 64 * exp.size() && w < 5000) begin
      @(posedge clk);
      w++;
    end
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK("stream_bits", 64 * exp.size(), q.size())
    foreach (exp[j]) begin
      for (int b = 0; b < 64; b++) got[b] = q[j * 64 + b];
      `CHK("stream_word", exp[j], got)
    end
    `CHK("buffer_stall", 1'b1, stall_seen)
    `CHK("clock_lane_toggled", 1'b1, clk_tog)
    `CHK("pads_idle_after_burst", 10'h3ff, {pad_p, pad_n})
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    void'($urandom(32'h68bac169));
    do_reset(2'b00, 1'b0);
    sleep_try(60, 5'h01, 5'h00, 5'h00);
    sleep_try(130, 5'h01, 5'h00, 5'h01);
    sleep_try(130, 5'h01, 5'h01, 5'h01);
    sleep_try(130, 5'h00, 5'h01, 5'h00);
    for (int i = 0; i < 4; i++) begin
      sleep_try(130, 5'h02 << i, 5'h00, 5'h02 << i);
      sleep_try(130, 5'h00, 5'h02 << i, 5'h00);
    end
    run_line(3);
    do_reset(2'b11, 1'b1);
    run_line(4);
    do_reset(2'b01, 1'b0);
    run_line(3);
    // Code 10 acts as a single lane
    do_reset(2'b10, 1'b1);
    run_line(2);
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule // test_csi2_tx_video_port
